/* hw/dpl_pkg.sv */
/*
 * Constants and types shared by the page and register load unit:
 * register offsets, field positions, opcodes, reset values, region codes.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package dpl_pkg;

   // register byte offsets
   localparam logic [5:0] OFS_CTRL    = 6'h00;
   localparam logic [5:0] OFS_CMD     = 6'h04;
   localparam logic [5:0] OFS_MEMWORD = 6'h08;
   localparam logic [5:0] OFS_LIMM    = 6'h0C;
   localparam logic [5:0] OFS_STATUS  = 6'h10;
   localparam logic [5:0] OFS_ADDR    = 6'h14;
   localparam logic [5:0] OFS_PROD    = 6'h18;
   localparam logic [5:0] OFS_PROD_LO = 6'h1C;
   localparam logic [5:0] OFS_ACC     = 6'h20;
   localparam logic [5:0] OFS_MULT    = 6'h24;

   // control fields
   localparam int CTRL_LATER_BIT = 0;
   localparam int CTRL_PM_LSB    = 1;

   // command fields
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_IND_BIT  = 4;
   localparam int CMD_NXV_BIT  = 5;
   localparam int CMD_NXT_LSB  = 6;
   localparam int CMD_ADDR_LSB = 9;
   localparam int CMD_DES_LSB  = 16;
   localparam int CMD_IMM_LSB  = 19;

   // status fields
   localparam int ST_DP_LSB   = 0;
   localparam int ST_PTR_LSB  = 12;
   localparam int ST_REG_LSB  = 16;
   localparam int ST_TGT_LSB  = 20;
   localparam int ST_ERR_BIT  = 24;
   localparam int ST_BUSY_BIT = 25;

   // opcodes
   localparam logic [3:0] OP_LOAD_PAGE     = 4'h1;
   localparam logic [3:0] OP_LOAD_PAGE_IMM = 4'h2;
   localparam logic [3:0] OP_LOAD_MAPPED   = 4'h3;
   localparam logic [3:0] OP_LOAD_PROD_HI  = 4'h4;
   localparam logic [3:0] OP_LOAD_IDX_LONG = 4'h5;
   localparam logic [3:0] OP_LOAD_MULT_ACC = 4'h6;
   localparam logic [3:0] OP_LOAD_SEL_PTR  = 4'h7;

   // page map
   localparam logic [8:0] PAGE_EXT_MIN   = 9'h008;
   localparam logic [8:0] PAGE_BLOCK_MIN = 9'h004;
   localparam logic [6:0] BLOCK_TWO_BASE = 7'h60;

   // reset values
   localparam logic [2:0]  CTRL_RESET = 3'h1;
   localparam logic [8:0]  DP_RESET   = 9'h000;
   localparam logic [2:0]  PTR_RESET  = 3'h0;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      REG_INTERNAL,
      REG_BLOCK_ZERO,
      REG_BLOCK_ONE,
      REG_BLOCK_TWO,
      REG_EXTERNAL
   } dpl_region_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_EXEC
   } dpl_state_type;

endpackage : dpl_pkg

/* hw/dpl_index_file.sv */
/*
 * Index register file: one write port, one read port whose data come
 * out of a register one cycle after the address.
 * Assumes a single clock; no reset on the array itself.
 */
`timescale 1ns/100ps
`default_nettype none

module dpl_index_file
  import dpl_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
)
(
   // clock
   input  wire logic                     clk_sys,
   // write port
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   // read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data_q
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   // elaboration refuses geometries the core cannot use
   if (DEPTH < 2 || WIDTH < 8)
   begin : g_bad_geometry
      $error("dpl_index_file: unsupported geometry");
   end

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // read after write to the same word sees the old value
   always_ff @(posedge clk_sys)
   begin
      rd_data_q <= mem_q[rd_addr];
   end

endmodule : dpl_index_file

`default_nettype wire

/* hw/dpl_core.sv */
/*
 * Page pointer and register load unit of a fixed-point signal processor,
 * executing one load instruction per command written over Avalon-MM.
 * Assumes software supplies the addressed memory word and long immediate
 * in registers before writing the command; memory itself lives outside.
 */
`timescale 1ns/100ps
`default_nettype none

module dpl_core
  import dpl_pkg::*;
#(
   parameter int IDX_DEPTH = 8
)
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // data access result
   output logic      [15:0] data_addr,
   output dpl_region_type   data_region,
   // mapped register copy
   output logic             mapped_wr_valid,
   output logic      [15:0] mapped_wr_addr,
   output logic      [15:0] mapped_wr_data
);

   localparam int PTR_W = $clog2(IDX_DEPTH);

   // elaboration refuses every depth other than 8, the count the three-bit selector addresses
   if (IDX_DEPTH != 8)
   begin : g_bad_depth
      $error("dpl_core: the selector pointer is three bits wide");
   end

   logic           rst_meta_q;
   logic           rst_n;
   logic [2:0]     ctrl_q;
   logic [31:0]    cmd_q;
   logic [15:0]    memword_q;
   logic [15:0]    limm_q;
   logic [8:0]     dp_q;
   logic [2:0]     ptr_q;
   logic [31:0]    prod_q;
   logic [31:0]    acc_q;
   logic [15:0]    mult_q;
   logic           err_q;
   logic           rd_ack_q;
   dpl_state_type  state_q;
   dpl_region_type tgt_region_q;
   logic [15:0]    idx_rdata;
   logic [15:0]    oper_addr;
   logic [31:0]    rd_mux;
   logic [3:0]     op;
   logic           later;
   logic           ind;
   logic           busy;
   logic           exec;
   logic           wr_take;
   logic           rd_take;
   logic           cmd_take;
   logic           accesses_mem;
   logic           legal;
   logic [2:0]     next_ptr;
   logic [2:0]     des_sel;

   function automatic logic [31:0] dpl_be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : dpl_be_merge

   // early parts see only on-chip pages 0 and 1
   function automatic dpl_region_type dpl_region(input logic later_v, input logic [15:0] a);
      logic [8:0] page;
      page = a[15:7];
      if (!later_v)
      begin
         return REG_INTERNAL;
      end
      if (page >= PAGE_EXT_MIN)
      begin
         return REG_EXTERNAL;
      end
      if (page >= PAGE_BLOCK_MIN)
      begin
         return page[1] ? REG_BLOCK_ONE : REG_BLOCK_ZERO;
      end
      if (page == 9'h000 && a[6:0] >= BLOCK_TWO_BASE)
      begin
         return REG_BLOCK_TWO;
      end
      return REG_INTERNAL;
   endfunction : dpl_region

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   assign later    = ctrl_q[CTRL_LATER_BIT];
   assign op       = cmd_q[CMD_OP_LSB +: 4];
   assign ind      = cmd_q[CMD_IND_BIT];
   assign busy     = (state_q != ST_IDLE);
   assign exec     = (state_q == ST_EXEC);
   assign wr_take  = avs_write & ~busy;
   assign rd_take  = avs_read & ~busy & ~rd_ack_q;
   assign cmd_take = wr_take & (avs_address == OFS_CMD);
   assign avs_waitrequest = busy | (avs_read & ~rd_ack_q);

   // early parts have two index registers and a one-bit selector
   assign next_ptr = later ? cmd_q[CMD_NXT_LSB +: 3] : {2'b00, cmd_q[CMD_NXT_LSB]};
   assign des_sel  = later ? cmd_q[CMD_DES_LSB +: 3] : {2'b00, cmd_q[CMD_DES_LSB]};

   assign legal = (op == OP_LOAD_PAGE) || (op == OP_LOAD_PAGE_IMM) || (op == OP_LOAD_PROD_HI)
               || (op == OP_LOAD_IDX_LONG) || (op == OP_LOAD_MULT_ACC) || (op == OP_LOAD_SEL_PTR)
               || (op == OP_LOAD_MAPPED && later);
   assign accesses_mem = (op == OP_LOAD_PAGE) || (op == OP_LOAD_MAPPED) || (op == OP_LOAD_PROD_HI)
                      || (op == OP_LOAD_MULT_ACC);

   always_comb
   begin
      if (op == OP_LOAD_MAPPED)
      begin
         oper_addr = {9'h000, ind ? idx_rdata[6:0] : cmd_q[CMD_ADDR_LSB +: 7]};
      end
      else if (ind)
      begin
         oper_addr = idx_rdata;
      end
      else
      begin
         oper_addr = {dp_q, cmd_q[CMD_ADDR_LSB +: 7]};
      end
   end

   dpl_index_file #(
      .WIDTH (16),
      .DEPTH (IDX_DEPTH)
   ) u_index_file (
      .clk_sys   (clk_sys),
      .wr_en     (exec && op == OP_LOAD_IDX_LONG),
      .wr_addr   (des_sel[PTR_W-1:0]),
      .wr_data   (limm_q),
      .rd_addr   (ptr_q[PTR_W-1:0]),
      .rd_data_q (idx_rdata)
   );

   // fetch gives the index file one cycle to present the selected register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:  state_q <= cmd_take ? ST_FETCH : ST_IDLE;
            ST_FETCH: state_q <= ST_EXEC;
            ST_EXEC:  state_q <= ST_IDLE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q    <= CTRL_RESET;
         cmd_q     <= WORD_RESET;
         memword_q <= WORD_RESET[15:0];
         limm_q    <= WORD_RESET[15:0];
      end
      else if (wr_take)
      begin
         case (avs_address)
            OFS_CTRL:    ctrl_q    <= 3'(dpl_be_merge({29'h0, ctrl_q}, avs_writedata, avs_byteenable));
            OFS_CMD:     cmd_q     <= avs_writedata;
            OFS_MEMWORD: memword_q <= 16'(dpl_be_merge({16'h0, memword_q}, avs_writedata, avs_byteenable));
            OFS_LIMM:    limm_q    <= 16'(dpl_be_merge({16'h0, limm_q}, avs_writedata, avs_byteenable));
            default:     ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dp_q <= DP_RESET;
      end
      else if (exec && op == OP_LOAD_PAGE)
      begin
         dp_q <= later ? memword_q[8:0] : {8'h00, memword_q[0]};
      end
      else if (exec && op == OP_LOAD_PAGE_IMM)
      begin
         dp_q <= later ? cmd_q[CMD_IMM_LSB +: 9] : {8'h00, cmd_q[CMD_IMM_LSB]};
      end
   end

   // pointer moves after the access that used it
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ptr_q <= PTR_RESET;
      end
      else if (exec && op == OP_LOAD_SEL_PTR)
      begin
         ptr_q <= later ? cmd_q[CMD_IMM_LSB +: 3] : {2'b00, cmd_q[CMD_IMM_LSB]};
      end
      else if (exec && legal && ind && cmd_q[CMD_NXV_BIT])
      begin
         ptr_q <= next_ptr;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prod_q <= WORD_RESET;
      end
      else if (exec && op == OP_LOAD_PROD_HI)
      begin
         prod_q[31:16] <= memword_q;
      end
      else if (wr_take && avs_address == OFS_PROD_LO)
      begin
         prod_q[15:0] <= 16'(dpl_be_merge({16'h0, prod_q[15:0]}, avs_writedata, avs_byteenable));
      end
   end

   // mode 00 none, 01 left 1, 10 left 4, 11 arithmetic right 6
   function automatic logic [31:0] dpl_prod_shift(input logic [31:0] p, input logic [1:0] pm);
      case (pm)
         2'b01:   return {p[30:0], 1'b0};
         2'b10:   return {p[27:0], 4'h0};
         2'b11:   return {{6{p[31]}}, p[31:6]};
         default: return p;
      endcase
   endfunction : dpl_prod_shift

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q  <= WORD_RESET;
         mult_q <= WORD_RESET[15:0];
      end
      else if (exec && op == OP_LOAD_MULT_ACC)
      begin
         mult_q <= memword_q;
         acc_q  <= acc_q + (later ? dpl_prod_shift(prod_q, ctrl_q[CTRL_PM_LSB +: 2]) : prod_q);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_addr    <= WORD_RESET[15:0];
         data_region  <= REG_INTERNAL;
         tgt_region_q <= REG_INTERNAL;
         err_q        <= 1'b0;
      end
      else if (exec)
      begin
         err_q <= ~legal;
         if (legal && accesses_mem)
         begin
            data_addr   <= oper_addr;
            data_region <= dpl_region(later, oper_addr);
         end
         if (legal && op == OP_LOAD_MAPPED)
         begin
            tgt_region_q <= dpl_region(later, limm_q);
         end
      end
   end

   // the mapped register's contents arrive through the memory word register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mapped_wr_valid <= 1'b0;
         mapped_wr_addr  <= WORD_RESET[15:0];
         mapped_wr_data  <= WORD_RESET[15:0];
      end
      else
      begin
         mapped_wr_valid <= exec && legal && op == OP_LOAD_MAPPED;
         if (exec && legal && op == OP_LOAD_MAPPED)
         begin
            mapped_wr_addr <= limm_q;
            mapped_wr_data <= memword_q;
         end
      end
   end

   always_comb
   begin
      rd_mux = WORD_RESET;
      case (avs_address)
         OFS_CTRL:    rd_mux = {29'h0, ctrl_q};
         OFS_CMD:     rd_mux = cmd_q;
         OFS_MEMWORD: rd_mux = {16'h0, memword_q};
         OFS_LIMM:    rd_mux = {16'h0, limm_q};
         OFS_STATUS:
         begin
            rd_mux[ST_DP_LSB +: 9]  = dp_q;
            rd_mux[ST_PTR_LSB +: 3] = ptr_q;
            rd_mux[ST_REG_LSB +: 3] = data_region;
            rd_mux[ST_TGT_LSB +: 3] = tgt_region_q;
            rd_mux[ST_ERR_BIT]      = err_q;
            rd_mux[ST_BUSY_BIT]     = busy;
         end
         OFS_ADDR:    rd_mux = {mapped_wr_addr, data_addr};
         OFS_PROD:    rd_mux = prod_q;
         OFS_PROD_LO: rd_mux = {16'h0, prod_q[15:0]};
         OFS_ACC:     rd_mux = acc_q;
         OFS_MULT:    rd_mux = {16'h0, mult_q};
         default:     rd_mux = WORD_RESET;
      endcase
   end

   // reads always take at least one wait cycle so read data come from a flop
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ack_q     <= 1'b0;
         avs_readdata <= WORD_RESET;
      end
      else
      begin
         rd_ack_q <= rd_take;
         if (rd_take)
         begin
            avs_readdata <= rd_mux;
         end
      end
   end

   a_page_early_lsb: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && op == OP_LOAD_PAGE && !later |=> dp_q == {8'h00, $past(memword_q[0])})
      else $error("early page load kept more than the lsb");

   a_page_later_nine: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && op == OP_LOAD_PAGE_IMM && later |=> dp_q == $past(cmd_q[CMD_IMM_LSB +: 9]))
      else $error("later immediate page load wrong");

   a_direct_addr_concat: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && !ind && legal && accesses_mem && op != OP_LOAD_MAPPED
      |=> data_addr == {$past(dp_q), $past(cmd_q[CMD_ADDR_LSB +: 7])})
      else $error("direct address not page and field");

   a_external_region: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(data_addr) && later && data_addr[15:7] >= PAGE_EXT_MIN |-> data_region == REG_EXTERNAL)
      else $error("high page not external");

   a_mapped_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && later && op == OP_LOAD_MAPPED |=> data_addr[15:7] == 9'h000 && mapped_wr_valid)
      else $error("mapped register address upper bits set");

   a_prod_high_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && op == OP_LOAD_PROD_HI
      |=> prod_q[31:16] == $past(memword_q) && prod_q[15:0] == $past(prod_q[15:0]))
      else $error("product high load disturbed low half");

   a_ptr_next_update: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && legal && ind && cmd_q[CMD_NXV_BIT] && op != OP_LOAD_SEL_PTR |=> ptr_q == $past(next_ptr))
      else $error("selector pointer not updated after access");

   a_cmd_two_waits: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_take |=> avs_waitrequest ##1 avs_waitrequest ##1 !busy)
      else $error("command did not finish in two cycles");

   a_early_acc_plain: assert property (@(posedge clk_sys) disable iff (!rst_n)
      exec && op == OP_LOAD_MULT_ACC && !later |=> acc_q == $past(acc_q) + $past(prod_q))
      else $error("early accumulate shifted the product");

endmodule : dpl_core

`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking bench for dpl_core: hand-written scenarios over Avalon-MM.
 * Assumes the dpl_pkg register map and the core's hand-over timing.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin failures++; \
   $display("Error %0t: got %h expected %h", $time, act, exp); end end

module tb
  import dpl_pkg::*;
;
   logic           clk_sys;
   logic           arst_n;
   logic [5:0]     avs_address;
   logic           avs_read;
   logic           avs_write;
   logic [31:0]    avs_writedata;
   logic [3:0]     avs_byteenable;
   logic [31:0]    avs_readdata;
   logic           avs_waitrequest;
   logic [15:0]    data_addr;
   dpl_region_type data_region;
   logic           mapped_wr_valid;
   logic [15:0]    mapped_wr_addr;
   logic [15:0]    mapped_wr_data;
   logic [31:0]    rd;
   int             failures;
   int             compares;
   int             pulses;

   dpl_core #(.IDX_DEPTH(8)) i_dut (
      .clk_sys         (clk_sys),
      .arst_n          (arst_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .data_addr       (data_addr),
      .data_region     (data_region),
      .mapped_wr_valid (mapped_wr_valid),
      .mapped_wr_addr  (mapped_wr_addr),
      .mapped_wr_data  (mapped_wr_data)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // the copy pulse stands one cycle, so count it at every edge
   always @(posedge clk_sys)
      if (mapped_wr_valid === 1'b1)
         pulses++;

   // waitrequest is read right after the edge, before any update lands
   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus_wr

   task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus_rd

   function automatic logic [31:0] cmd(input logic [3:0] op, input logic ind, input logic nxv,
                                       input logic [2:0] nxt, input logic [6:0] fa,
                                       input logic [2:0] des, input logic [8:0] imm);
      return {4'h0, imm, des, fa, nxt, nxv, ind, op};
   endfunction : cmd

   // status read also waits out the last of the command's two busy cycles
   task automatic run(input logic [31:0] c);
      bus_wr(OFS_CMD, c);
      bus_rd(OFS_STATUS, rd);
   endtask : run

   task automatic t_reset;
      bus_rd(OFS_CTRL, rd);
      `CHK(rd, {29'h0, CTRL_RESET})
      bus_rd(OFS_STATUS, rd);
      `CHK(rd, 32'h0000_0000)
      bus_wr(6'h28, 32'hFFFF_FFFF);
      bus_rd(6'h28, rd);
      `CHK(rd, 32'h0000_0000)
      // only the enabled lane may change
      bus_wr(OFS_MEMWORD, 32'h0000_1234);
      avs_byteenable <= 4'h2;
      bus_wr(OFS_MEMWORD, 32'hFFFF_FFFF);
      avs_byteenable <= 4'hF;
      bus_rd(OFS_MEMWORD, rd);
      `CHK(rd, 32'h0000_FF34)
      $display("test reset done");
   endtask : t_reset

   task automatic t_pages;
      logic [8:0]     pg [8] = '{9'h008, 9'h007, 9'h006, 9'h005, 9'h004, 9'h003, 9'h000, 9'h000};
      logic [6:0]     fa [8] = '{7'h00, 7'h7F, 7'h00, 7'h7F, 7'h00, 7'h7F, 7'h60, 7'h5F};
      dpl_region_type rg [8] = '{REG_EXTERNAL, REG_BLOCK_ONE, REG_BLOCK_ONE, REG_BLOCK_ZERO,
                                 REG_BLOCK_ZERO, REG_INTERNAL, REG_BLOCK_TWO, REG_INTERNAL};
      bus_wr(OFS_MEMWORD, 32'h0000_FFFF);
      run(cmd(OP_LOAD_PAGE, 0, 0, 0, 0, 0, 0));
      `CHK(rd[8:0], 9'h1FF)
      run(cmd(OP_LOAD_PROD_HI, 0, 0, 0, 7'h2A, 0, 0));
      `CHK(data_addr, 16'hFFAA)
      for (int i = 0; i < 8; i++)
      begin
         run(cmd(OP_LOAD_PAGE_IMM, 0, 0, 0, 0, 0, pg[i]));
         run(cmd(OP_LOAD_PROD_HI, 0, 0, 0, fa[i], 0, 0));
         `CHK(data_addr, {pg[i], fa[i]})
         `CHK(data_region, rg[i])
      end
      $display("test pages done");
   endtask : t_pages

   task automatic t_early;
      int p;
      bus_wr(OFS_CTRL, 32'h0000_0000);
      bus_wr(OFS_MEMWORD, 32'h0000_FFFF);
      run(cmd(OP_LOAD_PAGE, 0, 0, 0, 0, 0, 0));
      `CHK(rd[8:0], 9'h001)
      run(cmd(OP_LOAD_PROD_HI, 0, 0, 0, 7'h00, 0, 0));
      `CHK(data_addr, 16'h0080)
      bus_wr(OFS_MEMWORD, 32'h0000_FFFE);
      run(cmd(OP_LOAD_PAGE, 0, 0, 0, 0, 0, 0));
      `CHK(rd[8:0], 9'h000)
      run(cmd(OP_LOAD_PAGE_IMM, 0, 0, 0, 0, 0, 9'h1FF));
      `CHK(rd[8:0], 9'h001)
      run(cmd(OP_LOAD_PAGE_IMM, 0, 0, 0, 0, 0, 9'h1FE));
      `CHK(rd[8:0], 9'h000)
      run(cmd(OP_LOAD_PROD_HI, 0, 0, 0, 7'h7F, 0, 0));
      `CHK(data_addr, 16'h007F)
      p = pulses;
      run(cmd(OP_LOAD_MAPPED, 0, 0, 0, 7'h05, 0, 0));
      `CHK(rd[ST_ERR_BIT], 1'b1)
      `CHK(pulses, p)
      // early parts keep a one-bit selector
      run(cmd(OP_LOAD_SEL_PTR, 0, 0, 0, 0, 0, 9'h007));
      `CHK(rd[14:12], 3'h1)
      bus_wr(OFS_CTRL, 32'h0000_0001);
      $display("test early done");
   endtask : t_early

   task automatic t_index;
      int p;
      bus_wr(OFS_PROD_LO, 32'h0000_1234);
      bus_wr(OFS_MEMWORD, 32'h0000_ABCD);
      run(cmd(OP_LOAD_PROD_HI, 0, 0, 0, 0, 0, 0));
      bus_rd(OFS_PROD, rd);
      `CHK(rd, 32'hABCD_1234)
      bus_wr(OFS_LIMM, 32'h0000_8123);
      run(cmd(OP_LOAD_IDX_LONG, 0, 0, 0, 0, 3'h6, 0));
      run(cmd(OP_LOAD_SEL_PTR, 0, 0, 0, 0, 0, 9'h006));
      `CHK(rd[14:12], 3'h6)
      run(cmd(OP_LOAD_PROD_HI, 1, 1, 3'h2, 7'h11, 0, 0));
      `CHK(data_addr, 16'h8123)
      `CHK(rd[14:12], 3'h2)
      run(cmd(OP_LOAD_SEL_PTR, 0, 0, 0, 0, 0, 9'h006));
      run(cmd(OP_LOAD_PAGE_IMM, 0, 0, 0, 0, 0, 9'h1FF));
      bus_wr(OFS_MEMWORD, 32'h0000_5555);
      bus_wr(OFS_LIMM, 32'h0000_0400);
      p = pulses;
      run(cmd(OP_LOAD_MAPPED, 1, 0, 0, 7'h11, 0, 0));
      `CHK(data_addr, 16'h0023)
      `CHK(mapped_wr_addr, 16'h0400)
      `CHK(mapped_wr_data, 16'h5555)
      `CHK(pulses, p + 1)
      `CHK(rd[ST_TGT_LSB +: 3], REG_EXTERNAL)
      run(cmd(OP_LOAD_MAPPED, 0, 0, 0, 7'h45, 0, 0));
      `CHK(data_addr, 16'h0045)
      $display("test index done");
   endtask : t_index

   task automatic t_mac;
      logic [31:0] sh [4] = '{32'h0001_0002, 32'h0002_0004, 32'h0010_0020, 32'h0000_0400};
      logic [31:0] acc;
      acc = 32'h0000_0000;
      bus_wr(OFS_PROD_LO, 32'h0000_0002);
      bus_wr(OFS_MEMWORD, 32'h0000_0001);
      run(cmd(OP_LOAD_PROD_HI, 0, 0, 0, 0, 0, 0));
      for (int m = 0; m < 5; m++)
      begin
         // last pass: earliest variant with a shift mode set must not shift
         bus_wr(OFS_CTRL, (m < 4) ? {29'h0, m[1:0], 1'b1} : 32'h0000_0002);
         bus_wr(OFS_MEMWORD, 32'h0000_0033 + m);
         run(cmd(OP_LOAD_MULT_ACC, 0, 0, 0, 0, 0, 0));
         acc = acc + sh[(m < 4) ? m : 0];
         bus_rd(OFS_ACC, rd);
         `CHK(rd, acc)
         bus_rd(OFS_MULT, rd);
         `CHK(rd[15:0], 16'h0033 + m[15:0])
      end
      bus_wr(OFS_CTRL, 32'h0000_0001);
      $display("test accumulate done");
   endtask : t_mac

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   initial
   begin
      arst_n         = 1'b0;
      avs_address    = 6'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'hF;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_pages();
      t_early();
      t_index();
      t_mac();
      close_out();
   end

   // whole run needs a few hundred cycles; this is far beyond it
   initial
   begin
      #(20000 * 8);
      failures++;
      close_out();
   end

endmodule : tb
`undef CHK
`default_nettype wire
